// *** ctp_can_pin_ctrl.sv ***
// CAN transceiver digital pin control: modes, drivers, receive, reset.
`timescale 1ns/100ps
`default_nettype none
`include "ctp_consts.svh"

module ctp_can_pin_ctrl (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst_b,
   // Supplies and supervision
   input  wire logic           battery_supply_ok,
   input  wire logic           second_battery_supply_ok,
   input  wire logic           main_reg_uv,
   output logic                main_reg_en,
   output logic                second_reg_en,
   output logic                lin2_fail_safe,
   // Reset pin, open drain
   input  wire logic           reset_inout_n_in,
   output logic                reset_inout_n_out,
   output logic                reset_inout_n_oe,
   // Mode control
   input  wire logic           mode_req_stb,
   input  wire ctp_pkg::ctp_mode_t mode_req,
   output ctp_pkg::ctp_mode_t  mode,
   // Controller pins
   input  wire logic           txd_in,
   input  wire logic           txd_driven,
   output logic                rxd_out,
   input  wire logic           rxd_sense,
   // Bus side
   input  wire logic           bus_rx_dominant,
   input  wire logic           remote_wake,
   output logic                bus_high_line_drv_en,
   output logic                bus_low_line_drv_en,
   output logic                bus_bias_en,
   output logic                dom_timeout_flag,
   output logic                rxd_clamp_flag,
   // Local wake
   input  wire logic           local_wake_in,
   input  wire logic           local_wake_en,
   input  wire ctp_pkg::ctp_edge_t local_wake_edge,
   // Sensor supply
   input  wire logic           sensor_en_req,
   input  wire logic           sensor_ov_det,
   input  wire logic           sensor_uv_det,
   input  wire logic           sensor_ov_capt_en,
   input  wire logic           sensor_uv_capt_en,
   output logic                sensor_supply_en,
   output logic                sensor_ov_event,
   output logic                sensor_uv_event
);
   import ctp_pkg::*;

   // ************************************************************
   // Constants and state
   // ************************************************************
   localparam ctp_cnt_t DOM_CYC   = 12'(`CTP_DOM_TIMEOUT_CYC);
   localparam ctp_cnt_t RST_CYC   = 12'(`CTP_RESET_DELAY_CYC);
   localparam ctp_cnt_t CLAMP_CYC = 12'(`CTP_CLAMP_CYC);
   // Every count fits the 12-bit counter type.
   // A longer time needs a wider type.

   // One record holds all state; the logic below fills a copy.
   ctp_main_st_t s_q;
   ctp_main_st_t s_d;
   logic         txd_eff;
   logic         local_wake;
   logic         wake_ev;
   logic         tx_ok;

   // ************************************************************
   // Local wake detector
   // ************************************************************
   // Unused local wake should be switched off by software; the
   // enable only arms the detector in the low-power modes.
   // The filter runs in every mode, so its level has settled
   // by the time a low-power mode arms the hold timer.
   ctp_wake_filter u_wake (
      .clk        (clk),
      .rst_b      (rst_b),
      .enable     (local_wake_en &&
                   (s_q.mode == CTP_SLEEP || s_q.mode == CTP_STANDBY)),
      .edge_sel   (local_wake_edge),
      .wake_in    (local_wake_in),
      .wake_pulse (local_wake)
   );

   // ************************************************************
   // Next state
   // ************************************************************
   // Fields not assigned below keep their registered value.
   always_comb begin
      s_d = s_q;
      s_d.ov_evt = 1'b0;
      s_d.uv_evt = 1'b0;
      // The internal pull-up makes an undriven input read high.
      txd_eff = txd_in | ~txd_driven;
      // Local and remote wake share one path.
      wake_ev = local_wake | remote_wake;
      tx_ok = 1'b0;

      // Supplies and power-up modes.
      // Priority: supply loss, power-up, external reset, wake
      // from Sleep, then a request; a request for the unpowered
      // mode is ignored, as only the supply reaches it.
      s_d.second_on = second_battery_supply_ok;
      s_d.fail_safe = second_battery_supply_ok & ~battery_supply_ok;
      if (!battery_supply_ok) begin
         s_d.mode = CTP_OFF;
      end else if (s_q.mode == CTP_OFF) begin
         s_d.mode = CTP_STANDBY;
      end else if (!reset_inout_n_in && !s_q.rst_low) begin
         // An external reset returns the transceiver to Standby.
         s_d.mode = CTP_STANDBY;
      end else if (s_q.mode == CTP_SLEEP && wake_ev) begin
         s_d.mode = CTP_STANDBY;
      end else if (mode_req_stb && mode_req != CTP_OFF) begin
         s_d.mode = mode_req;
      end

      // Wake flag is set in the low-power modes and cleared on
      // leaving them; a wake in the entry cycle from Normal or Silent sets it.
      // It survives Sleep to Standby; only Normal, Silent or supply loss
      // clears it, so a wake stays visible until software acts on it.
      if ((s_d.mode == CTP_STANDBY || s_d.mode == CTP_SLEEP) &&
          (s_q.mode == CTP_STANDBY || s_q.mode == CTP_SLEEP ||
           s_q.mode == CTP_OFF)) begin
         if (wake_ev) begin
            s_d.wake_flag = 1'b1;
         end
      end else if (wake_ev && s_d.mode != CTP_OFF &&
                   s_d.mode != CTP_NORMAL && s_d.mode != CTP_SILENT) begin
         s_d.wake_flag = 1'b1;
      end else begin
         s_d.wake_flag = 1'b0;
      end

      // Reset pin: low under undervoltage and for the delay after.
      // The unpowered mode restarts the delay, so every power-up
      // gets a full delay.
      // A new undervoltage restarts it too.
      if (main_reg_uv || s_q.mode == CTP_OFF) begin
         s_d.rst_low = 1'b1;
         s_d.rst_cnt = '0;
      end else if (s_q.rst_low) begin
         if (s_q.rst_cnt == RST_CYC - 12'h001) begin
            s_d.rst_low = 1'b0;
            s_d.rst_cnt = '0;
         end else begin
            s_d.rst_cnt = ctp_sat_inc(s_q.rst_cnt, RST_CYC);
         end
      end

      // Dominant time-out: runs while the input is low.
      // The count advances in Normal mode only and holds elsewhere;
      // once the flag is set it stops until the input rises.
      if (txd_eff) begin
         s_d.dom_cnt = '0;
         s_d.dom_to  = 1'b0;
      end else if (s_q.mode == CTP_NORMAL && !s_q.dom_to) begin
         if (s_q.dom_cnt == DOM_CYC - 12'h001) begin
            s_d.dom_to = 1'b1;
         end else begin
            s_d.dom_cnt = ctp_sat_inc(s_q.dom_cnt, DOM_CYC);
         end
      end

      // Input stuck low at Normal entry locks until it goes high.
      // The lock uses the level of the entry cycle itself.
      // A low that starts a cycle later drives as usual.
      if (s_d.mode == CTP_NORMAL && s_q.mode != CTP_NORMAL) begin
         s_d.tx_lock = ~txd_eff;
      end else if (txd_eff || s_d.mode != CTP_NORMAL) begin
         s_d.tx_lock = 1'b0;
      end

      // Receive clamping: bus dominant yet the receive pin reads
      // recessive means the controller cannot see the bus.
      // Only a low receive pin clears the flag; a recessive bus
      // merely restarts the count.
      if (rxd_sense && bus_rx_dominant) begin
         if (s_q.clamp_cnt == CLAMP_CYC - 12'h001) begin
            s_d.clamped = 1'b1;
         end else begin
            s_d.clamp_cnt = ctp_sat_inc(s_q.clamp_cnt, CLAMP_CYC);
         end
      end else if (!rxd_sense) begin
         s_d.clamp_cnt = '0;
         s_d.clamped = 1'b0;
      end else begin
         s_d.clamp_cnt = '0;
      end

      // Bus drivers are only ever on in Normal mode.
      // Next-state values drop the drivers in the same cycle as a
      // mode change, a time-out or a clamp.
      // Only this path may turn them on.
      tx_ok = (s_d.mode == CTP_NORMAL) && !s_d.dom_to &&
              !s_d.tx_lock && !s_d.clamped;
      s_d.drive = tx_ok && !txd_eff;

      // Receive output.
      // The unpowered mode leaves it recessive.
      case (s_d.mode)
         CTP_NORMAL,
         CTP_SILENT:  s_d.rxd = ~bus_rx_dominant;
         CTP_STANDBY,
         CTP_SLEEP:   s_d.rxd = ~s_d.wake_flag;
         default:     s_d.rxd = 1'b1;
      endcase

      // Sensor supply: off after reset, events only when captured.
      // Events mark rising comparator edges, one per excursion,
      // and only while the supply was already on.
      // Capture gates the event, never the comparator.
      s_d.sens_en = sensor_en_req && s_d.mode != CTP_OFF;
      s_d.ov_prev = sensor_ov_det;
      s_d.uv_prev = sensor_uv_det;
      if (s_q.sens_en && sensor_ov_capt_en) begin
         s_d.ov_evt = sensor_ov_det & ~s_q.ov_prev;
      end
      if (s_q.sens_en && sensor_uv_capt_en) begin
         s_d.uv_evt = sensor_uv_det & ~s_q.uv_prev;
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Reset clears all, then sets the recessive receive output and
   // the asserted reset pin.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q         <= '0;
         s_q.mode    <= CTP_OFF;
         s_q.rxd     <= `CTP_RXD_RST;
         s_q.rst_low <= `CTP_RST_LOW_RST;
         s_q.sens_en <= `CTP_SENS_EN_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign mode                 = s_q.mode;

   // Main regulator off only when unpowered or asleep.
   assign main_reg_en          = s_q.mode != CTP_OFF &&
                                 s_q.mode != CTP_SLEEP;
   // The second regulator rests in Sleep.
   assign second_reg_en        = s_q.second_on &&
                                 s_q.mode != CTP_SLEEP;
   assign lin2_fail_safe       = s_q.fail_safe;

   // Open drain: the pin only pulls low, the enable says when.
   assign reset_inout_n_out    = 1'b0;
   assign reset_inout_n_oe     = s_q.rst_low;

   assign rxd_out              = s_q.rxd;
   assign bus_high_line_drv_en = s_q.drive;
   assign bus_low_line_drv_en  = s_q.drive;

   // Biasing stays off when asleep or unpowered so the lines float.
   assign bus_bias_en          = s_q.mode == CTP_NORMAL ||
                                 s_q.mode == CTP_SILENT ||
                                 s_q.mode == CTP_STANDBY;

   // Status flags for the supervising logic.
   assign dom_timeout_flag     = s_q.dom_to;
   assign rxd_clamp_flag       = s_q.clamped;

   assign sensor_supply_en     = s_q.sens_en;
   assign sensor_ov_event      = s_q.ov_evt;
   assign sensor_uv_event      = s_q.uv_evt;

endmodule
`default_nettype wire

// *** ctp_consts.svh ***
// Timing constants and reset values for the CAN transceiver pin control.
`ifndef CTP_CONSTS_SVH
`define CTP_CONSTS_SVH

// ***************************************************************
// Clock
// ***************************************************************
`define CTP_CLK_PERIOD_PS        8000

// ***************************************************************
// Times in picoseconds and their cycle counts
// ***************************************************************
// Least times round up to whole cycles.
`define CTP_DOM_TIMEOUT_PS       30000000
`define CTP_DOM_TIMEOUT_CYC \
   ((`CTP_DOM_TIMEOUT_PS + `CTP_CLK_PERIOD_PS - 1) / `CTP_CLK_PERIOD_PS)
`define CTP_RESET_DELAY_PS       20000000
`define CTP_RESET_DELAY_CYC \
   ((`CTP_RESET_DELAY_PS + `CTP_CLK_PERIOD_PS - 1) / `CTP_CLK_PERIOD_PS)
`define CTP_CLAMP_TIME_PS        10000000
`define CTP_CLAMP_CYC \
   ((`CTP_CLAMP_TIME_PS + `CTP_CLK_PERIOD_PS - 1) / `CTP_CLK_PERIOD_PS)
`define CTP_WAKE_HOLD_PS         25000000
`define CTP_WAKE_HOLD_CYC \
   ((`CTP_WAKE_HOLD_PS + `CTP_CLK_PERIOD_PS - 1) / `CTP_CLK_PERIOD_PS)
`define CTP_WAKE_FILT_PS         1000000
`define CTP_WAKE_FILT_CYC \
   ((`CTP_WAKE_FILT_PS + `CTP_CLK_PERIOD_PS - 1) / `CTP_CLK_PERIOD_PS)

// ***************************************************************
// Reset values
// ***************************************************************
`define CTP_RXD_RST              1'b1
`define CTP_RST_LOW_RST          1'b1
`define CTP_SENS_EN_RST          1'b0

`endif

// *** ctp_pkg.sv ***
// Types and shared arithmetic for the CAN transceiver pin control.
package ctp_pkg;

   typedef logic [11:0] ctp_cnt_t;

   typedef enum logic [2:0] {
      CTP_OFF,
      CTP_STANDBY,
      CTP_NORMAL,
      CTP_SILENT,
      CTP_SLEEP
   } ctp_mode_t;

   typedef enum logic [1:0] {
      CTP_EDGE_RISE,
      CTP_EDGE_FALL,
      CTP_EDGE_BOTH
   } ctp_edge_t;

   typedef struct packed {
      logic       filt_lvl;
      ctp_cnt_t   filt_cnt;
      logic       hold_act;
      ctp_cnt_t   hold_cnt;
      logic       wake;
   } ctp_wake_st_t;

   typedef struct packed {
      ctp_mode_t  mode;
      logic       second_on;
      logic       fail_safe;
      ctp_cnt_t   rst_cnt;
      logic       rst_low;
      ctp_cnt_t   dom_cnt;
      logic       dom_to;
      logic       tx_lock;
      ctp_cnt_t   clamp_cnt;
      logic       clamped;
      logic       wake_flag;
      logic       drive;
      logic       rxd;
      logic       sens_en;
      logic       ov_prev;
      logic       uv_prev;
      logic       ov_evt;
      logic       uv_evt;
   } ctp_main_st_t;

   // Counter step that stops at the limit instead of wrapping.
   function automatic ctp_cnt_t ctp_sat_inc(input ctp_cnt_t c,
                                            input ctp_cnt_t lim);
      ctp_sat_inc = (c >= lim) ? lim : c + 12'h001;
   endfunction

endpackage

// *** ctp_wake_filter.sv ***
// Local wake input noise filter and edge-plus-hold detector.
`timescale 1ns/100ps
`default_nettype none
`include "ctp_consts.svh"

module ctp_wake_filter (
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst_b,
   // Control
   input  wire logic           enable,
   input  wire ctp_pkg::ctp_edge_t edge_sel,
   // Pin and result
   input  wire logic           wake_in,
   output logic                wake_pulse
);
   import ctp_pkg::*;

   localparam ctp_cnt_t FILT_CYC = 12'(`CTP_WAKE_FILT_CYC);
   localparam ctp_cnt_t HOLD_CYC = 12'(`CTP_WAKE_HOLD_CYC);

   ctp_wake_st_t s_q;
   ctp_wake_st_t s_d;
   logic         edge_hit;

   always_comb begin
      s_d = s_q;
      s_d.wake = 1'b0;
      edge_hit = 1'b0;
      // The filtered level only moves once the raw pin has disagreed
      // with it for the whole filter time, so glitches never count.
      if (wake_in == s_q.filt_lvl) begin
         s_d.filt_cnt = '0;
      end else if (s_q.filt_cnt == FILT_CYC - 12'h001) begin
         s_d.filt_lvl = wake_in;
         s_d.filt_cnt = '0;
         case (edge_sel)
            CTP_EDGE_RISE: edge_hit = wake_in;
            CTP_EDGE_FALL: edge_hit = ~wake_in;
            CTP_EDGE_BOTH: edge_hit = 1'b1;
            default:       edge_hit = 1'b0;
         endcase
      end else begin
         s_d.filt_cnt = ctp_sat_inc(s_q.filt_cnt, FILT_CYC);
      end
      if (!enable) begin
         s_d.hold_act = 1'b0;
         s_d.hold_cnt = '0;
      end else if (edge_hit) begin
         s_d.hold_act = 1'b1;
         s_d.hold_cnt = '0;
      end else if (s_q.hold_act) begin
         // An unselected edge of the level inside the hold time cancels it.
         if (s_d.filt_lvl != s_q.filt_lvl) begin
            s_d.hold_act = 1'b0;
         end else if (s_q.hold_cnt == HOLD_CYC) begin
            s_d.hold_act = 1'b0;
            s_d.wake = 1'b1;
         end else begin
            s_d.hold_cnt = ctp_sat_inc(s_q.hold_cnt, HOLD_CYC);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign wake_pulse = s_q.wake;

endmodule
`default_nettype wire

// *** ctp_can_pin_ctrl_properties.sv ***
// Concurrent checks on the ports of the CAN transceiver pin control.
`timescale 1ns/100ps
`default_nettype none
module ctp_can_pin_ctrl_chk
   import ctp_pkg::*;
(
   // Clock and reset
   input wire logic      clk,
   input wire logic      rst_b,
   // Watched ports
   input wire ctp_mode_t mode,
   input wire logic      main_reg_uv,
   input wire logic      reset_inout_n_oe,
   input wire logic      txd_in,
   input wire logic      txd_driven,
   input wire logic      bus_high_line_drv_en,
   input wire logic      bus_low_line_drv_en,
   input wire logic      bus_bias_en,
   input wire logic      dom_timeout_flag,
   input wire logic      rxd_out,
   input wire logic      bus_rx_dominant,
   input wire logic      sensor_ov_event,
   input wire logic      sensor_ov_capt_en
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [11:0] ok_q;
   logic [11:0] low_q;
   wire         tx_low = txd_driven && !txd_in;
   wire         rx_md = (mode == CTP_NORMAL) || (mode == CTP_SILENT);
   // Saturating counters so a long run never wraps into a false match.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ok_q <= 12'h000;
         low_q <= 12'h000;
      end else begin
         ok_q <= (main_reg_uv || mode == CTP_OFF) ? 12'h000 :
                 ok_q + {11'h000, ~&ok_q};
         low_q <= (tx_low && mode == CTP_NORMAL) ?
                  low_q + {11'h000, ~&low_q} : 12'h000;
      end
   end
   chk_uv_reset: assert property (
      main_reg_uv |-> ##[1:2] reset_inout_n_oe)
      else $error("reset pin not pulled on undervoltage");
   chk_reset_hold: assert property (
      $fell(reset_inout_n_oe) |-> ok_q >= 12'h9bf && ok_q <= 12'h9c9)
      else $error("reset pin released at wrong time");
   chk_sens_evt: assert property (
      sensor_ov_event |-> $past(sensor_ov_capt_en))
      else $error("sensor event without capture enable");
   chk_recessive_tx: assert property (
      (mode == CTP_NORMAL && !tx_low) |=> !bus_high_line_drv_en)
      else $error("drivers on with transmit high");
   chk_stby_off: assert property (
      (mode == CTP_STANDBY && $past(mode) == CTP_STANDBY)
      |-> !bus_high_line_drv_en && !bus_low_line_drv_en)
      else $error("drivers on in standby");
   chk_sleep_hiz: assert property (
      (mode == CTP_SLEEP && $past(mode) == CTP_SLEEP)
      |-> !bus_bias_en && !bus_high_line_drv_en && !bus_low_line_drv_en)
      else $error("bus not released in sleep");
   chk_to_drop: assert property (
      dom_timeout_flag |-> !bus_high_line_drv_en && !bus_low_line_drv_en)
      else $error("drivers on after time-out");
   chk_to_time: assert property (
      $rose(dom_timeout_flag) |-> low_q >= 12'hea1 && low_q <= 12'heab)
      else $error("time-out at wrong count");
   chk_to_clear: assert property (
      (dom_timeout_flag && !tx_low) |-> ##[1:2] !dom_timeout_flag)
      else $error("time-out not cleared by transmit high");
   chk_rxd_follow: assert property (
      (rx_md && $past(rx_md)) |-> rxd_out == !$past(bus_rx_dominant))
      else $error("receive output does not follow bus");
   cov_timeout: cover property ($rose(dom_timeout_flag));
   cov_reset: cover property ($fell(reset_inout_n_oe));
   cov_wake: cover property (mode == CTP_SLEEP ##1 mode == CTP_STANDBY);
endmodule
bind ctp_can_pin_ctrl ctp_can_pin_ctrl_chk u_chk (.*);
`default_nettype wire

// *** ctp_can_partner.sv ***
// Model of the protocol controller and the bus at the transceiver pins.
`timescale 1ns/100ps
`default_nettype none
module ctp_can_partner (
   // Clock
   input  wire logic clk,
   // Scenario controls
   input  wire logic tx_bit,
   input  wire logic tx_float,
   input  wire logic node_dom,
   input  wire logic rxd_stuck,
   // Transceiver outputs
   input  wire logic bus_high_line_drv_en,
   input  wire logic rxd_out,
   input  wire logic reset_inout_n_oe,
   // Transceiver inputs
   output logic      txd_in,
   output logic      txd_driven,
   output logic      bus_rx_dominant,
   output logic      rxd_sense,
   output logic      reset_inout_n_in
);
   logic noise_q = 1'b0;
   // A floating pin shows no stable level, so a design reading it sees noise.
   always_ff @(posedge clk)
      noise_q <= ~noise_q;
   assign txd_driven = !tx_float;
   assign txd_in = tx_float ? noise_q : tx_bit;
   // Wired bus: any dominant driver wins over recessive.
   assign bus_rx_dominant = bus_high_line_drv_en | node_dom;
   assign rxd_sense = rxd_stuck | rxd_out;
   assign reset_inout_n_in = !reset_inout_n_oe;
endmodule
`default_nettype wire

// *** ctp_can_pin_ctrl_bench.sv ***
// Self-checking bench for the CAN transceiver pin control.
`timescale 1ns/100ps
`default_nettype none
module ctp_can_pin_ctrl_bench;
   import ctp_pkg::*;
   logic      clk, rst_b, battery_supply_ok, second_battery_supply_ok;
   logic      main_reg_uv, main_reg_en, second_reg_en, lin2_fail_safe;
   logic      reset_inout_n_in, reset_inout_n_out, reset_inout_n_oe;
   logic      mode_req_stb, txd_in, txd_driven, rxd_out, rxd_sense;
   logic      bus_rx_dominant, remote_wake, bus_high_line_drv_en;
   logic      bus_low_line_drv_en, bus_bias_en, dom_timeout_flag;
   logic      rxd_clamp_flag, local_wake_in, local_wake_en, sensor_en_req;
   logic      sensor_ov_det, sensor_uv_det, sensor_ov_capt_en;
   logic      sensor_uv_capt_en, sensor_supply_en, sensor_ov_event;
   logic      sensor_uv_event, tx_bit, tx_float, node_dom, rxd_stuck;
   ctp_mode_t mode_req, mode;
   ctp_edge_t local_wake_edge;
   int        fail_count, checked, k;
   logic [31:0] n;
   ctp_can_pin_ctrl u_dut (.*);
   ctp_can_partner u_far (.*);
   always #4 clk = ~clk;
   task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic cyc(int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   // Bounded wait; running out ends the run as a failure.
   task automatic await(string s, ref logic sig, input logic v, input int mx);
      k = 0;
      while (sig !== v && k < mx) begin
         cyc(1);
         k++;
      end
      if (sig !== v) begin
         chk(s, sig, v);
         print_verdict();
      end
   endtask
   task automatic go(ctp_mode_t m);
      @(posedge clk);
      mode_req <= m;
      mode_req_stb <= 1'b1;
      @(posedge clk);
      mode_req_stb <= 1'b0;
      cyc(1);
      chk("mode", mode, m);
   endtask
   task automatic t_power();
      chk("mode", mode, CTP_STANDBY);
      chk("main_reg", main_reg_en, 1'b1);
      chk("second_reg", second_reg_en, 1'b1);
      chk("sensor_en", sensor_supply_en, 1'b0);
      chk("rxd", rxd_out, 1'b1);
      await("rst_oe", reset_inout_n_oe, 1'b0, 2600);
      chk("rst_hold", k > 2490, 1'b1);
      @(posedge clk);
      main_reg_uv <= 1'b1;
      cyc(3);
      chk("rst_uv", reset_inout_n_oe, 1'b1);
      chk("rst_out", reset_inout_n_out, 1'b0);
      @(posedge clk);
      main_reg_uv <= 1'b0;
      await("rst_oe", reset_inout_n_oe, 1'b0, 2600);
      chk("rst_hold", k > 2490, 1'b1);
      @(posedge clk);
      battery_supply_ok <= 1'b0;
      cyc(3);
      chk("fail_safe", lin2_fail_safe, 1'b1);
      chk("second_reg", second_reg_en, 1'b1);
      @(posedge clk);
      battery_supply_ok <= 1'b1;
      cyc(3);
      chk("mode", mode, CTP_STANDBY);
      await("rst_oe", reset_inout_n_oe, 1'b0, 2600);
      $display("power test done");
   endtask
   task automatic t_drive();
      @(posedge clk);
      tx_bit <= 1'b0;
      cyc(3);
      chk("drv_stby", bus_high_line_drv_en, 1'b0);
      @(posedge clk);
      tx_bit <= 1'b1;
      go(CTP_NORMAL);
      chk("bias", bus_bias_en, 1'b1);
      chk("drv_rec", bus_high_line_drv_en, 1'b0);
      @(posedge clk);
      tx_bit <= 1'b0;
      cyc(3);
      chk("drv_h", bus_high_line_drv_en, 1'b1);
      chk("drv_l", bus_low_line_drv_en, 1'b1);
      chk("rxd_dom", rxd_out, 1'b0);
      @(posedge clk);
      tx_float <= 1'b1;
      cyc(3);
      chk("drv_float", bus_high_line_drv_en, 1'b0);
      chk("rxd_rec", rxd_out, 1'b1);
      @(posedge clk);
      tx_float <= 1'b0;
      tx_bit <= 1'b1;
      go(CTP_SILENT);
      @(posedge clk);
      node_dom <= 1'b1;
      cyc(3);
      chk("rxd_silent", rxd_out, 1'b0);
      @(posedge clk);
      node_dom <= 1'b0;
      go(CTP_NORMAL);
      @(posedge clk);
      tx_bit <= 1'b0;
      await("dom_to", dom_timeout_flag, 1'b1, 3800);
      chk("to_time", k > 3740, 1'b1);
      chk("drv_to", bus_high_line_drv_en, 1'b0);
      @(posedge clk);
      tx_bit <= 1'b1;
      cyc(3);
      chk("to_clear", dom_timeout_flag, 1'b0);
      @(posedge clk);
      tx_bit <= 1'b0;
      cyc(3);
      chk("drv_again", bus_high_line_drv_en, 1'b1);
      go(CTP_STANDBY);
      go(CTP_NORMAL);
      cyc(20);
      chk("drv_lock", bus_high_line_drv_en, 1'b0);
      @(posedge clk);
      tx_bit <= 1'b1;
      @(posedge clk);
      tx_bit <= 1'b0;
      cyc(3);
      chk("drv_unlock", bus_high_line_drv_en, 1'b1);
      @(posedge clk);
      tx_bit <= 1'b1;
      rxd_stuck <= 1'b1;
      node_dom <= 1'b1;
      await("clamp", rxd_clamp_flag, 1'b1, 1300);
      chk("clamp_time", k > 1240, 1'b1);
      @(posedge clk);
      tx_bit <= 1'b0;
      cyc(3);
      chk("drv_clamp", bus_high_line_drv_en, 1'b0);
      @(posedge clk);
      tx_bit <= 1'b1;
      rxd_stuck <= 1'b0;
      await("unclamp", rxd_clamp_flag, 1'b0, 10);
      @(posedge clk);
      node_dom <= 1'b0;
      $display("drive test done");
   endtask
   task automatic t_wake();
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         local_wake_edge <= ctp_edge_t'(i);
         local_wake_in <= (i == 1);
         local_wake_en <= 1'b1;
         cyc(200);
         go(CTP_NORMAL);
         go(CTP_SLEEP);
         chk("bias_sleep", bus_bias_en, 1'b0);
         @(posedge clk);
         local_wake_in <= ~local_wake_in;
         cyc(40);
         @(posedge clk);
         local_wake_in <= ~local_wake_in;
         cyc(3400);
         chk("glitch", mode, CTP_SLEEP);
         @(posedge clk);
         local_wake_in <= ~local_wake_in;
         await("wake", rxd_out, 1'b0, 3400);
         chk("wake_hold", k > 3200, 1'b1);
         chk("wake_mode", mode, CTP_STANDBY);
      end
      @(posedge clk);
      local_wake_en <= 1'b0;
      go(CTP_NORMAL);
      go(CTP_STANDBY);
      chk("rxd_idle", rxd_out, 1'b1);
      @(posedge clk);
      remote_wake <= 1'b1;
      @(posedge clk);
      remote_wake <= 1'b0;
      cyc(2);
      chk("rxd_wake", rxd_out, 1'b0);
      $display("wake test done");
   endtask
   task automatic t_sensor();
      @(posedge clk);
      sensor_en_req <= 1'b1;
      cyc(3);
      chk("sensor_en", sensor_supply_en, 1'b1);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         {sensor_ov_capt_en, sensor_uv_capt_en} <= {2{i[0]}};
         {sensor_ov_det, sensor_uv_det} <= 2'h3;
         n = 0;
         repeat (4) begin
            cyc(1);
            n += sensor_ov_event + sensor_uv_event;
         end
         chk("events", n, 2 * i);
         @(posedge clk);
         {sensor_ov_det, sensor_uv_det} <= 2'h0;
         cyc(3);
      end
      $display("sensor test done");
   endtask
   initial begin
      {clk, rst_b, main_reg_uv, mode_req_stb, remote_wake, local_wake_in,
       local_wake_en, sensor_en_req, sensor_ov_det, sensor_uv_det,
       sensor_ov_capt_en, sensor_uv_capt_en, tx_float, node_dom,
       rxd_stuck} = '0;
      {battery_supply_ok, second_battery_supply_ok, tx_bit} = '1;
      mode_req = CTP_STANDBY;
      local_wake_edge = CTP_EDGE_RISE;
      fail_count = 0;
      checked = 0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      cyc(2);
      t_power();
      t_drive();
      t_wake();
      t_sensor();
      print_verdict();
   end
endmodule
`default_nettype wire
